// ---- rtl/flash_loader_bridge.sv ----
// bridge from the test-port serial link to the serial configuration memory
`timescale 1ns/100ps
`include "flash_loader_params.svh"
module flash_loader_bridge #(
  parameter int DATA_W = `BYTE_BITS,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter logic [2:0] AS_SCHEME = `AS_SCHEME_CODE
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // test-port link, asynchronous to clk
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_data_in,
  output logic link_data_out,
  output logic link_busy,
  // serial memory pins
  output flash_loader_pkg::flash_pins_t flash_pins,
  input wire logic memory_data_in,
  // configuration control, straps and pins from outside
  input wire logic [2:0] scheme_select,
  input wire logic chain_config_done,
  input wire logic reconfig_request_n,
  // same-domain configuration controller status
  input wire logic test_config_active,
  input wire logic as_config_request,
  input wire logic bitstream_compressed,
  input wire logic reconfig_instr,
  // configuration outcomes
  output logic as_config_abort,
  output logic decompress_enable,
  output logic bitstream_refused,
  output logic user_mode,
  output logic programming_done,
  output logic device_reconfig
);
  // link synchronisers: stage one feeds stage two only
  logic [2:0] lclk_q, lclk_d;
  logic [1:0] lfrm_q, lfrm_d;
  logic [1:0] ldat_q, ldat_d;
  logic [1:0] mdi_q, mdi_d; // memory data in
  logic [1:0] rcfg_pin_q, rcfg_pin_d; // reconfiguration pin
  logic [2:0] scheme_select_a_q, scheme_select_a_d, scheme_select_b_q, scheme_select_b_d; // scheme strap bits, two stage
  flash_loader_pkg::link_sample_t ls; // sampled link view
  // link-side byte assembly
  logic [DATA_W-1:0] rx_q, rx_d;
  logic [`BIT_CNT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [DATA_W-1:0] tx_q, tx_d, ret_q, ret_d; // read-back shift, last byte from memory
  logic push_v, push_rdy; // fifo filling handshake
  logic [DATA_W-1:0] push_byte;
  // memory-side shifter
  flash_loader_pkg::shift_state_t st_q, st_d;
  logic [DATA_W-1:0] sh_q, sh_d, cap_q, cap_d; // outgoing and captured bits
  logic [`BIT_CNT_W-1:0] bit_q, bit_d;
  logic [`DIV_W-1:0] div_q, div_d;
  flash_loader_pkg::flash_pins_t pins_q, pins_d;
  logic pop_v, pop_rdy; // fifo draining handshake
  logic [DATA_W-1:0] pop_byte;
  // configuration bookkeeping
  logic enabled; // scheme strap picks active serial
  logic busy_q, busy_d, out_q, out_d; // link full flag, read-back bit
  logic abort_q, abort_d, dec_q, dec_d, refuse_q, refuse_d; // arbitration outcomes
  logic umode_q, umode_d, done_q, done_d; // user mode, programming finished
  logic seen_q, seen_d, recfg_q, recfg_d; // a frame was opened, reconfiguration pulse
  logic [`RCFG_W-1:0] rlow_q, rlow_d; // low-time counter of the pin

  // synchroniser next values: plain shifts
  always_comb begin
    lclk_d = {lclk_q[1:0], link_clk};
    lfrm_d = {lfrm_q[0], link_frame};
    ldat_d = {ldat_q[0], link_data_in};
    mdi_d = {mdi_q[0], memory_data_in};
    rcfg_pin_d = {rcfg_pin_q[0], reconfig_request_n};
    scheme_select_a_d = scheme_select;
    scheme_select_b_d = scheme_select_a_q;
  end

  // edges are found only from the second and third stages
  assign ls.clk_rise = lclk_q[1] & ~lclk_q[2];
  assign ls.clk_fall = ~lclk_q[1] & lclk_q[2];
  assign ls.frame = lfrm_q[1];
  assign ls.data = ldat_q[1];
  assign enabled = (scheme_select_b_q == AS_SCHEME);

  // link side: shift in on rising test clock, return on falling
  always_comb begin
    rx_d = rx_q;
    rx_cnt_d = rx_cnt_q;
    tx_d = tx_q;
    push_v = 1'b0;
    push_byte = {rx_q[DATA_W-2:0], ls.data};
    if (!ls.frame || !enabled) begin
      // framing lost: start a fresh byte next time
      rx_cnt_d = `BIT_CNT_ZERO;
    end else if (ls.clk_rise) begin
      rx_d = push_byte;
      rx_cnt_d = `BIT_CNT_W'(rx_cnt_q + 1'b1);
      if (rx_cnt_q == `BIT_CNT_LAST) begin
        // whole byte; a full fifo drops it, host must watch link_busy
        push_v = 1'b1;
        tx_d = ret_q;
      end
    end else if (ls.clk_fall) begin
      tx_d = {tx_q[DATA_W-2:0], 1'b0};
    end
    out_d = tx_d[DATA_W-1];
    busy_d = ~push_rdy;
  end

  // buffer between the two sides, memory side can stall it
  byte_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_byte),
    .out_valid(pop_v),
    .out_ready(pop_rdy),
    .out_data(pop_byte)
  );

  // memory shifter: mode 0, msb first, capture at the end of the clock high phase
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cap_d = cap_q;
    bit_d = bit_q;
    div_d = div_q;
    pins_d = pins_q;
    ret_d = ret_q;
    pop_rdy = 1'b0;
    unique case (st_q)
      flash_loader_pkg::ST_IDLE: begin
        pins_d.sck = 1'b0;
        if (pop_v) begin
          pop_rdy = 1'b1;
          sh_d = pop_byte;
          bit_d = `BIT_CNT_ZERO;
          pins_d.cs_n = 1'b0;
          st_d = flash_loader_pkg::ST_LOAD;
        end else if (!ls.frame) begin
          // frame over and nothing queued: release the memory
          pins_d.cs_n = 1'b1;
          pins_d.mosi = 1'b0; // quiet data line while deselected
        end
      end
      flash_loader_pkg::ST_LOAD: begin
        // present data a half period before the rising clock
        pins_d.mosi = sh_q[DATA_W-1];
        div_d = `DIV_W'(`SCK_HALF_CYCLES);
        st_d = flash_loader_pkg::ST_LOW;
      end
      flash_loader_pkg::ST_LOW: begin
        if (div_q == `DIV_ONE) begin
          pins_d.sck = 1'b1;
          div_d = `DIV_W'(`SCK_HALF_CYCLES);
          st_d = flash_loader_pkg::ST_HIGH;
        end else begin
          div_d = `DIV_W'(div_q - 1'b1);
        end
      end
      flash_loader_pkg::ST_HIGH: begin
        if (div_q == `DIV_ONE) begin
          // sample late in the high phase to absorb the synchroniser
          cap_d = {cap_q[DATA_W-2:0], mdi_q[1]};
          pins_d.sck = 1'b0;
          sh_d = {sh_q[DATA_W-2:0], 1'b0};
          div_d = `DIV_W'(`SCK_HALF_CYCLES);
          if (bit_q == `BIT_CNT_LAST) begin
            ret_d = {cap_q[DATA_W-2:0], mdi_q[1]};
            st_d = flash_loader_pkg::ST_IDLE;
          end else begin
            bit_d = `BIT_CNT_W'(bit_q + 1'b1);
            pins_d.mosi = sh_q[DATA_W-2];
            st_d = flash_loader_pkg::ST_LOW;
          end
        end else begin
          div_d = `DIV_W'(div_q - 1'b1);
        end
      end
    endcase
  end

  // configuration arbitration and reconfiguration triggers
  always_comb begin
    abort_d = as_config_request & test_config_active;
    dec_d = as_config_request & ~test_config_active;
    refuse_d = test_config_active & bitstream_compressed;
    umode_d = 1'b1;
    seen_d = seen_q | (ls.frame & enabled);
    done_d = done_q;
    if (seen_q && !ls.frame && !pop_v && st_q == flash_loader_pkg::ST_IDLE) begin
      done_d = 1'b1;
    end
    // count the pin's low time; saturate at the threshold
    if (rcfg_pin_q[1]) begin
      rlow_d = '0;
    end else if (rlow_q != `RCFG_W'(`RECONFIG_MIN_CYCLES)) begin
      rlow_d = `RCFG_W'(rlow_q + 1'b1);
    end else begin
      rlow_d = rlow_q;
    end
    // only an explicit request reconfigures, never completion
    recfg_d = reconfig_instr | (rlow_d == `RCFG_W'(`RECONFIG_MIN_CYCLES) &&
      rlow_q != `RCFG_W'(`RECONFIG_MIN_CYCLES));
  end

  // single register stage for every group
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lclk_q <= '0;
      lfrm_q <= '0;
      ldat_q <= '0;
      mdi_q <= '0;
      rcfg_pin_q <= `RCFG_PIN_IDLE;
      scheme_select_a_q <= '0;
      scheme_select_b_q <= '0;
      rx_q <= '0;
      rx_cnt_q <= `BIT_CNT_ZERO;
      tx_q <= '0;
      ret_q <= '0;
      out_q <= 1'b0;
      busy_q <= 1'b0;
      st_q <= flash_loader_pkg::ST_IDLE;
      sh_q <= '0;
      cap_q <= '0;
      bit_q <= `BIT_CNT_ZERO;
      div_q <= '0;
      pins_q <= `PINS_IDLE;
      abort_q <= 1'b0;
      dec_q <= 1'b0;
      refuse_q <= 1'b0;
      umode_q <= 1'b0;
      done_q <= 1'b0;
      seen_q <= 1'b0;
      recfg_q <= 1'b0;
      rlow_q <= '0;
    end else if (clk_en) begin
      lclk_q <= lclk_d;
      lfrm_q <= lfrm_d;
      ldat_q <= ldat_d;
      mdi_q <= mdi_d;
      rcfg_pin_q <= rcfg_pin_d;
      scheme_select_a_q <= scheme_select_a_d;
      scheme_select_b_q <= scheme_select_b_d;
      rx_q <= rx_d;
      rx_cnt_q <= rx_cnt_d;
      tx_q <= tx_d;
      ret_q <= ret_d;
      out_q <= out_d;
      busy_q <= busy_d;
      st_q <= st_d;
      sh_q <= sh_d;
      cap_q <= cap_d;
      bit_q <= bit_d;
      div_q <= div_d;
      pins_q <= pins_d;
      abort_q <= abort_d;
      dec_q <= dec_d;
      refuse_q <= refuse_d;
      umode_q <= umode_d;
      done_q <= done_d;
      seen_q <= seen_d;
      recfg_q <= recfg_d;
      rlow_q <= rlow_d;
    end
  end

  // outputs straight from flip-flops
  assign link_data_out = out_q;
  assign link_busy = busy_q;
  assign flash_pins = pins_q;
  assign as_config_abort = abort_q;
  assign decompress_enable = dec_q;
  assign bitstream_refused = refuse_q;
  assign user_mode = umode_q;
  assign programming_done = done_q;
  assign device_reconfig = recfg_q;
endmodule

// ---- rtl/flash_loader_params.svh ----
// timing, encoding and sizing constants of the flash loader bridge
`ifndef FLASH_LOADER_PARAMS_SVH
`define FLASH_LOADER_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define RECONFIG_MIN_NS 500
`define RECONFIG_MIN_CYCLES ((`RECONFIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCK_HALF_CYCLES 4
`define BYTE_BITS 8
`define FIFO_DEPTH 4
`define BIT_CNT_W 3
`define BIT_CNT_LAST 3'h7
`define BIT_CNT_ZERO 3'h0
`define DIV_W 4
`define DIV_ONE 4'h1
`define RCFG_W 8
`define AS_SCHEME_CODE 3'h2
`define PINS_IDLE 3'h1
`define RCFG_PIN_IDLE 2'h3
`endif

// ---- rtl/flash_loader_pkg.sv ----
// types shared by the flash loader bridge
package flash_loader_pkg;
  // serial memory pins as driven by the bridge
  typedef struct packed {
    logic sck;
    logic mosi;
    logic cs_n;
  } flash_pins_t;
  // one sampled view of the test-port link
  typedef struct packed {
    logic clk_rise;
    logic clk_fall;
    logic frame;
    logic data;
  } link_sample_t;
  // memory-side shifter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_HIGH = 2'b10,
    ST_LOW = 2'b11
  } shift_state_t;
endpackage

// ---- rtl/byte_fifo.sv ----
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
  logic [AW-1:0] wr_q, wr_d; // write index
  logic [AW-1:0] rd_q, rd_d; // read index
  logic [AW:0] cnt_q, cnt_d; // fill level
  logic push, pop;

  // honest flags straight from the fill level
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // index and level arithmetic, wrapping at DEPTH
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
    end
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  // pointers reset; storage needs no reset since level guards it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      if (push) begin
        mem_q[wr_q] <= in_data;
      end
    end
  end
endmodule

// ---- verification/flash_loader_bridge_assertions.sv ----
// concurrent checks on the flash loader bridge ports
`timescale 1ns/100ps
module flash_loader_bridge_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration inputs
  input wire logic reconfig_request_n,
  input wire logic test_config_active,
  input wire logic as_config_request,
  input wire logic bitstream_compressed,
  input wire logic reconfig_instr,
  // outcomes and memory pins
  input wire logic as_config_abort,
  input wire logic decompress_enable,
  input wire logic bitstream_refused,
  input wire logic user_mode,
  input wire logic device_reconfig,
  input wire flash_loader_pkg::flash_pins_t flash_pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // one memory clock high phase: four cycles, then low
  sequence s_high4;
    flash_pins.sck [*4] ##1 !flash_pins.sck;
  endsequence
  // one reconfiguration pulse of a single cycle
  sequence s_pulse;
    device_reconfig ##1 !device_reconfig;
  endsequence
  chk_abort_set: assert property (as_config_request && test_config_active |=> as_config_abort)
    else $error("active serial load not aborted");
  chk_abort_clear: assert property (!as_config_request |=> !as_config_abort)
    else $error("abort without a request");
  chk_no_decomp: assert property (test_config_active |=> !decompress_enable)
    else $error("decompression during test port load");
  chk_refuse_comp: assert property (test_config_active && bitstream_compressed |=> bitstream_refused)
    else $error("compressed stream accepted");
  chk_user_mode: assert property (reset_n |=> user_mode)
    else $error("user mode not entered");
  chk_instr_pulse: assert property (reconfig_instr |=> s_pulse)
    else $error("no single reconfiguration pulse");
  chk_reconfig_cause: assert property (device_reconfig |-> $past(reconfig_instr) || !$past(reconfig_request_n))
    else $error("reconfiguration without a request");
  chk_idle_clock: assert property (flash_pins.cs_n |-> !flash_pins.sck)
    else $error("memory clock runs while deselected");
  chk_sck_high: assert property ($rose(flash_pins.sck) |-> s_high4)
    else $error("memory clock high phase wrong");
  chk_mosi_hold: assert property ($past(flash_pins.sck) && flash_pins.sck |-> $stable(flash_pins.mosi))
    else $error("memory data moved while clock high");
endmodule
bind flash_loader_bridge flash_loader_bridge_assertions u_flash_loader_bridge_assertions (.clk, .reset_n,
  .reconfig_request_n, .test_config_active, .as_config_request, .bitstream_compressed, .reconfig_instr,
  .as_config_abort, .decompress_enable, .bitstream_refused, .user_mode, .device_reconfig, .flash_pins);

// ---- verification/flash_memory_model.sv ----
// behavioural serial configuration memory behind the bridge
`timescale 1ns/100ps
module flash_memory_model #(
  parameter logic [7:0] REPLY = 8'hA5 // byte returned for each byte taken
) (
  // pins from the bridge
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  // data back to the bridge
  output logic miso
);
  logic [7:0] sh = 8'h00; // incoming shift
  logic [2:0] nin = 3'h0; // bits taken
  logic [2:0] nout = 3'h0; // bits returned
  logic [7:0] got [$]; // bytes taken, in order
  initial miso = 1'b0;
  // new window: first reply bit ready before the first clock
  always @(negedge cs_n) begin
    nin = 3'h0;
    nout = 3'h0;
    miso = REPLY[7];
  end
  // a released line shows the inverse, never a stale level
  always @(posedge cs_n) miso = ~miso;
  // take data on the rising clock, msb first
  always @(posedge sck) begin
    sh = {sh[6:0], mosi};
    nin = nin + 3'h1;
    if (nin == 3'h0) got.push_back(sh);
  end
  // next reply bit after each falling clock
  always @(negedge sck) begin
    nout = nout + 3'h1;
    miso = REPLY[3'h7 - nout];
  end
endmodule

// ---- verification/test_flash_loader_bridge.sv ----
// self-checking bench for the flash loader bridge
`timescale 1ns/100ps
module test_flash_loader_bridge;
  localparam logic [7:0] REPLY = 8'hA5; // memory reply byte
  // drive side
  logic clk = 1'b0, reset_n = 1'b0, link_clk = 1'b0, link_frame = 1'b0, link_data_in = 1'b0;
  logic [2:0] scheme_select = 3'h2;
  logic reconfig_request_n = 1'b1, reconfig_instr = 1'b0;
  logic test_config_active = 1'b0, as_config_request = 1'b0, bitstream_compressed = 1'b0;
  // observed side
  logic link_data_out, link_busy, memory_data_in, as_config_abort, decompress_enable;
  logic bitstream_refused, user_mode, programming_done, device_reconfig;
  flash_loader_pkg::flash_pins_t pins;
  int bad_count = 0, n_checks = 0, pulses = 0;
  logic [7:0] rb = 8'h00; // read-back bits caught at link clock falls
  always #5 clk = ~clk;
  // count reconfiguration pulses
  always @(posedge clk) if (device_reconfig === 1'b1) pulses <= pulses + 1;
  // chain done held low by unconfigured slaves; clock enable kept running
  flash_loader_bridge u_flash_loader_bridge (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link_clk(link_clk),
    .link_frame(link_frame), .link_data_in(link_data_in), .link_data_out(link_data_out), .link_busy(link_busy),
    .flash_pins(pins), .memory_data_in(memory_data_in), .scheme_select(scheme_select),
    .chain_config_done(1'b0),
    .reconfig_request_n(reconfig_request_n), .test_config_active(test_config_active),
    .as_config_request(as_config_request), .bitstream_compressed(bitstream_compressed),
    .reconfig_instr(reconfig_instr), .as_config_abort(as_config_abort), .decompress_enable(decompress_enable),
    .bitstream_refused(bitstream_refused), .user_mode(user_mode), .programming_done(programming_done),
    .device_reconfig(device_reconfig));
  flash_memory_model #(.REPLY(REPLY)) u_flash_memory_model (.sck(pins.sck), .mosi(pins.mosi),
    .cs_n(pins.cs_n), .miso(memory_data_in));
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one byte, msb first, 160 ns link clock; read-back caught at each fall
  task send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      link_data_in <= b[i];
      tick(8);
      link_clk <= 1'b1;
      tick(8);
      rb <= {rb[6:0], link_data_out};
      link_clk <= 1'b0;
    end
  endtask
  // close the frame and wait, bounded, for the select to drop
  task close_frame;
    link_frame <= 1'b0;
    for (int i = 0; i < 400 && pins.cs_n !== 1'b1; i++) tick(1);
    tick(2);
  endtask
  task t_reset;
    tick(6);
    chk(8'(user_mode), 8'h00, "user mode in reset");
    chk(8'(pins), 8'h01, "pins in reset");
    tick(6);
    reset_n <= 1'b1;
    tick(3);
    chk(8'(user_mode), 8'h01, "user mode with chain done low");
  endtask
  task t_forward;
    link_frame <= 1'b1;
    tick(4);
    send(8'h80);
    send(8'h3C);
    send(8'hFF);
    close_frame();
    chk(8'(u_flash_memory_model.got.size()), 8'h03, "byte count");
    chk(u_flash_memory_model.got[0], 8'h80, "byte 0");
    chk(u_flash_memory_model.got[1], 8'h3C, "byte 1");
    chk(u_flash_memory_model.got[2], 8'hFF, "byte 2");
    chk(rb, {REPLY[6:0], REPLY[7]}, "read-back");
    chk(8'(pins), 8'h01, "idle pins");
    chk(8'(programming_done), 8'h01, "programming done");
    chk(8'(link_busy), 8'h00, "fifo room after frame");
    chk(8'(pulses), 8'h00, "no self reconfiguration");
  endtask
  task t_scheme;
    scheme_select <= 3'h0;
    tick(4);
    link_frame <= 1'b1;
    send(8'h55);
    close_frame();
    chk(8'(u_flash_memory_model.got.size()), 8'h03, "wrong scheme forwarded");
    scheme_select <= 3'h2;
  endtask
  task t_arbitrate;
    for (int k = 0; k < 8; k++) begin
      {as_config_request, test_config_active, bitstream_compressed} <= 3'(k);
      tick(2);
      chk(8'(as_config_abort), 8'(k[2] & k[1]), "abort");
      chk(8'(decompress_enable), 8'(k[2] & !k[1]), "decompress");
      chk(8'(bitstream_refused), 8'(k[1] & k[0]), "refuse");
    end
    {as_config_request, test_config_active, bitstream_compressed} <= 3'h0;
  endtask
  task t_reconfig;
    reconfig_instr <= 1'b1;
    tick(1);
    reconfig_instr <= 1'b0;
    tick(3);
    chk(8'(pulses), 8'h01, "instruction pulse");
    reconfig_request_n <= 1'b0;
    tick(40);
    reconfig_request_n <= 1'b1;
    tick(10);
    chk(8'(pulses), 8'h01, "short pin pulse");
    reconfig_request_n <= 1'b0;
    tick(60);
    reconfig_request_n <= 1'b1;
    tick(5);
    chk(8'(pulses), 8'h02, "pin pulse");
  endtask
  // watchdog well beyond the expected run of under 10 us
  initial begin
    #200us;
    bad_count++;
    end_of_test();
  end
  // load, program, reconfigure in order
  initial begin
    t_reset();
    t_forward();
    t_scheme();
    t_arbitrate();
    t_reconfig();
    end_of_test();
  end
endmodule
